// File: aeu_pkg.sv
// Package with offsets, field positions and reset values of the uncorrectable error block
package aeu_pkg;

   // ----------------------------------------------------------------
   // Configuration space layout
   // ----------------------------------------------------------------
   localparam logic [11:0] AEU_HDR_DWORD_OFS   = 12'h100;
   localparam logic [11:0] AEU_NEXT_CAP_OFS    = 12'h102;
   localparam logic [11:0] AEU_STATUS_OFS      = 12'h104;
   localparam logic [11:0] AEU_MASK_OFS        = 12'h108;

   // ----------------------------------------------------------------
   // Header word fields
   // ----------------------------------------------------------------
   localparam logic [11:0] AEU_NEXT_PTR_VAL    = 12'h000;
   localparam logic [3:0]  AEU_CAP_VERSION_VAL = 4'h1;
   localparam int          AEU_NEXT_PTR_LSB    = 4;
   localparam int          AEU_HDR_LANE_LSB    = 16;

   // ----------------------------------------------------------------
   // Error bit positions, shared by status, mask and severity
   // ----------------------------------------------------------------
   localparam int AEU_BIT_UNSUPPORTED_REQUEST = 20;
   localparam int AEU_BIT_END_TO_END_CRC      = 19;
   localparam int AEU_BIT_MALFORMED_PACKET    = 18;
   localparam int AEU_BIT_RECEIVER_OVERFLOW   = 17;
   localparam int AEU_BIT_UNEXPECTED_CPL      = 16;
   localparam int AEU_BIT_COMPLETER_ABORT     = 15;
   localparam int AEU_BIT_COMPLETION_TIMEOUT  = 14;
   localparam int AEU_BIT_FLOW_CONTROL        = 13;
   localparam int AEU_BIT_POISONED_PACKET     = 12;
   localparam int AEU_BIT_SURPRISE_DOWN       = 5;
   localparam int AEU_BIT_LINK_PROTOCOL       = 4;

   // Implemented bits; all others read zero and ignore writes
   localparam logic [31:0] AEU_IMPL_MASK       = 32'h001f_f030;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [31:0] AEU_STATUS_RST      = 32'h0000_0000;
   localparam logic [31:0] AEU_MASK_RST        = 32'h0000_0000;
   localparam logic [31:0] AEU_RDATA_RST       = 32'h0000_0000;

endpackage : aeu_pkg

// File: aeu_sticky_status.sv
// Write-one-to-clear sticky error status bits
`timescale 1ns/1ps

module aeu_sticky_status (
   input  wire logic        i_clock,
   input  wire logic        i_nrst,
   input  wire logic [31:0] i_set,
   input  wire logic [31:0] i_clear,
   output logic      [31:0] o_status
);

   logic [31:0] status_r;
   logic [31:0] status_nxt;

   // ----------------------------------------------------------------
   // Per-bit next state
   // ----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < 32; g++) begin : g_bit
         always_comb begin
            if (!aeu_pkg::AEU_IMPL_MASK[g]) begin
               status_nxt[g] = 1'b0;
            end else if (i_set[g]) begin
               status_nxt[g] = 1'b1;
            end else if (i_clear[g]) begin
               status_nxt[g] = 1'b0;
            end else begin
               status_nxt[g] = status_r[g];
            end
         end
      end
   endgenerate

   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         status_r <= aeu_pkg::AEU_STATUS_RST;
      end else begin
         status_r <= status_nxt;
      end
   end

   assign o_status = status_r;

endmodule // aeu_sticky_status

// File: aeu_reporter.sv
// Mask and severity gating of new errors into upstream messages and log strobes
`timescale 1ns/1ps

module aeu_reporter (
   input  wire logic        i_clock,
   input  wire logic        i_nrst,
   input  wire logic [31:0] i_errors,
   input  wire logic [31:0] i_mask,
   input  wire logic [31:0] i_severity,
   output logic             o_report_fatal,
   output logic             o_report_nonfatal,
   output logic             o_log_valid,
   output logic      [31:0] o_log_errors
);

   logic [31:0] unmasked;
   logic        fatal_r;
   logic        fatal_nxt;
   logic        nonfatal_r;
   logic        nonfatal_nxt;
   logic        log_valid_r;
   logic        log_valid_nxt;
   logic [31:0] log_errors_r;
   logic [31:0] log_errors_nxt;

   // ----------------------------------------------------------------
   // Gating
   // ----------------------------------------------------------------
   always_comb begin
      unmasked       = i_errors & ~i_mask & aeu_pkg::AEU_IMPL_MASK;
      fatal_nxt      = |(unmasked & i_severity);
      nonfatal_nxt   = |(unmasked & ~i_severity);
      log_valid_nxt  = |unmasked;
      log_errors_nxt = unmasked;
   end

   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         fatal_r      <= 1'b0;
         nonfatal_r   <= 1'b0;
         log_valid_r  <= 1'b0;
         log_errors_r <= aeu_pkg::AEU_STATUS_RST;
      end else begin
         fatal_r      <= fatal_nxt;
         nonfatal_r   <= nonfatal_nxt;
         log_valid_r  <= log_valid_nxt;
         log_errors_r <= log_errors_nxt;
      end
   end

   assign o_report_fatal    = fatal_r;
   assign o_report_nonfatal = nonfatal_r;
   assign o_log_valid       = log_valid_r;
   assign o_log_errors      = log_errors_r;

endmodule // aeu_reporter

// File: aeu_uncorr_regs.sv
// Uncorrectable error header, status and mask registers in configuration space
//
// Behaviour
// - Next capability pointer reads zero
// - Version nibble reads one despite zero default
// - Status bits sticky, write one clears, reset zero
// - Bit 20 set on unsupported request completion
// - Bit 19 set on end-to-end CRC failure
// - Bit 18 set on malformed packet
// - Bit 17 set on receiver credit overflow
// - Bit 16 set on unexpected completion
// - Bit 15 set on completer abort completion
// - Bit 14 set on completion timeout
// - Bit 13 set on flow control violation
// - Bit 12 set on outgoing poisoned packet
// - Bit 5 is the surprise down status
// - Bit 4 set on link protocol error
// - Reserved bits read zero, ignore writes
// - Bit 0 undefined; here reads zero
// - Masked errors set status, not reported
// - Mask aligned to status, one masks, reset zero
// - Unmasked errors reported fatal or nonfatal by severity
`timescale 1ns/1ps

module aeu_uncorr_regs (
   input  wire logic        i_clock,
   input  wire logic        i_nrst,
   // Configuration access, dword aligned
   input  wire logic        i_cfg_rd,
   input  wire logic        i_cfg_wr,
   input  wire logic [11:0] i_cfg_addr,
   input  wire logic [3:0]  i_cfg_be,
   input  wire logic [31:0] i_cfg_wdata,
   output logic      [31:0] o_cfg_rdata,
   output logic             o_cfg_ack,
   // Error event pulses from the port logic
   input  wire logic        i_unsupported_request_flag,
   input  wire logic        i_end_to_end_crc_flag,
   input  wire logic        i_malformed_packet_flag,
   input  wire logic        i_receiver_overflow_flag,
   input  wire logic        i_unexpected_completion_flag,
   input  wire logic        i_completer_abort_flag,
   input  wire logic        i_completion_timeout_flag,
   input  wire logic        i_flow_control_protocol_flag,
   input  wire logic        i_poisoned_packet_flag,
   input  wire logic        i_surprise_down_flag,
   input  wire logic        i_link_protocol_flag,
   // Severity from the neighbouring severity register
   input  wire logic [31:0] i_severity,
   // Reporting and logging
   output logic             o_report_fatal,
   output logic             o_report_nonfatal,
   output logic             o_log_valid,
   output logic      [31:0] o_log_errors,
   output logic      [31:0] o_mask
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [31:0] err_vec;
   logic [31:0] be_bits;
   logic [31:0] status;
   logic [31:0] status_clear;
   logic        hit_hdr;
   logic        hit_status;
   logic        hit_mask;
   logic [15:0] hdr_word;
   logic [31:0] mask_r;
   logic [31:0] mask_nxt;
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;
   logic        ack_r;
   logic        ack_nxt;

   // ----------------------------------------------------------------
   // Error event vector
   // ----------------------------------------------------------------
   always_comb begin
      err_vec = 32'h0000_0000;
      err_vec[aeu_pkg::AEU_BIT_UNSUPPORTED_REQUEST] = i_unsupported_request_flag;
      err_vec[aeu_pkg::AEU_BIT_END_TO_END_CRC]      = i_end_to_end_crc_flag;
      err_vec[aeu_pkg::AEU_BIT_MALFORMED_PACKET]    = i_malformed_packet_flag;
      err_vec[aeu_pkg::AEU_BIT_RECEIVER_OVERFLOW]   = i_receiver_overflow_flag;
      err_vec[aeu_pkg::AEU_BIT_UNEXPECTED_CPL]      = i_unexpected_completion_flag;
      err_vec[aeu_pkg::AEU_BIT_COMPLETER_ABORT]     = i_completer_abort_flag;
      err_vec[aeu_pkg::AEU_BIT_COMPLETION_TIMEOUT]  = i_completion_timeout_flag;
      err_vec[aeu_pkg::AEU_BIT_FLOW_CONTROL]        = i_flow_control_protocol_flag;
      err_vec[aeu_pkg::AEU_BIT_POISONED_PACKET]     = i_poisoned_packet_flag;
      err_vec[aeu_pkg::AEU_BIT_SURPRISE_DOWN]       = i_surprise_down_flag;
      err_vec[aeu_pkg::AEU_BIT_LINK_PROTOCOL]       = i_link_protocol_flag;
   end

   // ----------------------------------------------------------------
   // Address decode and byte enables
   // ----------------------------------------------------------------
   always_comb begin
      hit_hdr    = (i_cfg_addr[11:2] == aeu_pkg::AEU_HDR_DWORD_OFS[11:2]);
      hit_status = (i_cfg_addr[11:2] == aeu_pkg::AEU_STATUS_OFS[11:2]);
      hit_mask   = (i_cfg_addr[11:2] == aeu_pkg::AEU_MASK_OFS[11:2]);
      be_bits    = {{8{i_cfg_be[3]}}, {8{i_cfg_be[2]}}, {8{i_cfg_be[1]}}, {8{i_cfg_be[0]}}};
   end

   // Header word: next pointer above the version nibble
   always_comb begin
      hdr_word = {aeu_pkg::AEU_NEXT_PTR_VAL, aeu_pkg::AEU_CAP_VERSION_VAL};
   end

   // ----------------------------------------------------------------
   // Status register
   // ----------------------------------------------------------------
   always_comb begin
      if (i_cfg_wr && hit_status) begin
         status_clear = i_cfg_wdata & be_bits & aeu_pkg::AEU_IMPL_MASK;
      end else begin
         status_clear = 32'h0000_0000;
      end
   end

   aeu_sticky_status u_status (
      .i_clock  (i_clock),
      .i_nrst   (i_nrst),
      .i_set    (err_vec),
      .i_clear  (status_clear),
      .o_status (status)
   );

   // ----------------------------------------------------------------
   // Mask register
   // ----------------------------------------------------------------
   always_comb begin
      mask_nxt = mask_r;
      if (i_cfg_wr && hit_mask) begin
         mask_nxt = ((mask_r & ~be_bits) | (i_cfg_wdata & be_bits)) & aeu_pkg::AEU_IMPL_MASK;
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         mask_r <= aeu_pkg::AEU_MASK_RST;
      end else begin
         mask_r <= mask_nxt;
      end
   end

   assign o_mask = mask_r;

   // ----------------------------------------------------------------
   // Upstream reporting
   // ----------------------------------------------------------------
   aeu_reporter u_report (
      .i_clock           (i_clock),
      .i_nrst            (i_nrst),
      .i_errors          (err_vec),
      .i_mask            (mask_r),
      .i_severity        (i_severity),
      .o_report_fatal    (o_report_fatal),
      .o_report_nonfatal (o_report_nonfatal),
      .o_log_valid       (o_log_valid),
      .o_log_errors      (o_log_errors)
   );

   // ----------------------------------------------------------------
   // Read path, answered one cycle after the request
   // ----------------------------------------------------------------
   always_comb begin
      rdata_nxt = rdata_r;
      ack_nxt   = i_cfg_rd | i_cfg_wr;
      if (i_cfg_rd) begin
         if (hit_hdr) begin
            // Low half belongs to the capability ID outside this block
            rdata_nxt = {hdr_word, 16'h0000};
         end else if (hit_status) begin
            rdata_nxt = status & aeu_pkg::AEU_IMPL_MASK;
         end else if (hit_mask) begin
            rdata_nxt = mask_r & aeu_pkg::AEU_IMPL_MASK;
         end else begin
            rdata_nxt = 32'h0000_0000;
         end
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         rdata_r <= aeu_pkg::AEU_RDATA_RST;
         ack_r   <= 1'b0;
      end else begin
         rdata_r <= rdata_nxt;
         ack_r   <= ack_nxt;
      end
   end

   assign o_cfg_rdata = rdata_r;
   assign o_cfg_ack   = ack_r;

endmodule // aeu_uncorr_regs

// File: aeu_uncorr_regs_checker.sv
// Assertion checker for the uncorrectable error registers
`timescale 1ns/1ps

module aeu_uncorr_regs_chk (
   input wire logic        i_clock,
   input wire logic        i_nrst,
   input wire logic        i_cfg_rd,
   input wire logic        i_cfg_wr,
   input wire logic [11:0] i_cfg_addr,
   input wire logic [3:0]  i_cfg_be,
   input wire logic [31:0] i_cfg_wdata,
   input wire logic [31:0] o_cfg_rdata,
   input wire logic        o_cfg_ack,
   input wire logic        i_unsupported_request_flag,
   input wire logic        i_end_to_end_crc_flag,
   input wire logic        i_malformed_packet_flag,
   input wire logic        i_receiver_overflow_flag,
   input wire logic        i_unexpected_completion_flag,
   input wire logic        i_completer_abort_flag,
   input wire logic        i_completion_timeout_flag,
   input wire logic        i_flow_control_protocol_flag,
   input wire logic        i_poisoned_packet_flag,
   input wire logic        i_surprise_down_flag,
   input wire logic        i_link_protocol_flag,
   input wire logic [31:0] i_severity,
   input wire logic        o_report_fatal,
   input wire logic        o_report_nonfatal,
   input wire logic        o_log_valid,
   input wire logic [31:0] o_log_errors,
   input wire logic [31:0] o_mask
);
   logic [31:0] errs;
   logic [31:0] unm;
   logic        fat;
   logic        nf;

   always_comb begin
      errs = {11'h000, i_unsupported_request_flag, i_end_to_end_crc_flag, i_malformed_packet_flag,
              i_receiver_overflow_flag, i_unexpected_completion_flag, i_completer_abort_flag,
              i_completion_timeout_flag, i_flow_control_protocol_flag, i_poisoned_packet_flag, 6'h00,
              i_surprise_down_flag, i_link_protocol_flag, 4'h0};
      unm = errs & ~o_mask;
      fat = |(unm & i_severity);
      nf = |(unm & ~i_severity);
   end

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_nrst);

   sequence s_access; i_cfg_rd || i_cfg_wr; endsequence
   sequence s_stat_rd; i_cfg_rd && i_cfg_addr[11:2] == 10'h041; endsequence
   sequence s_mask_rd; i_cfg_rd && i_cfg_addr[11:2] == 10'h042; endsequence
   sequence s_mask_wr; i_cfg_wr && i_cfg_addr[11:2] == 10'h042 && i_cfg_be == 4'hf; endsequence

   a_ack_follows: assert property (s_access |=> o_cfg_ack) else $error("no ack after access");
   a_ack_single: assert property (!i_cfg_rd && !i_cfg_wr |=> !o_cfg_ack) else $error("stray ack");
   a_hdr_value: assert property (i_cfg_rd && i_cfg_addr[11:2] == 10'h040 |=> o_cfg_rdata == 32'h0001_0000)
      else $error("header word wrong");
   a_rsvd_zero: assert property (s_stat_rd or s_mask_rd |=> (o_cfg_rdata & 32'hffe0_0fce) == 32'h0)
      else $error("reserved bits not zero");
   a_mask_write: assert property (s_mask_wr |=> o_mask == ($past(i_cfg_wdata) & 32'h001f_f030))
      else $error("mask write lost");
   a_mask_stable: assert property (!(i_cfg_wr && i_cfg_addr[11:2] == 10'h042) |=> $stable(o_mask))
      else $error("mask changed without write");
   a_err_sticky: assert property (errs != 32'h0 ##1 s_stat_rd |=> (o_cfg_rdata & $past(errs, 2)) == $past(errs, 2))
      else $error("error not in status");
   a_log_valid: assert property ($past(i_nrst) |-> o_log_valid == |$past(unm))
      else $error("log strobe wrong");
   a_log_bits: assert property (o_log_valid |-> o_log_errors == $past(unm)) else $error("log bits wrong");
   a_fatal_sev: assert property ($past(i_nrst) |-> o_report_fatal == $past(fat)) else $error("fatal report");
   a_nonfatal_sev: assert property ($past(i_nrst) |-> o_report_nonfatal == $past(nf))
      else $error("nonfatal report");
endmodule // aeu_uncorr_regs_chk

bind aeu_uncorr_regs aeu_uncorr_regs_chk u_chk (.i_clock, .i_nrst, .i_cfg_rd, .i_cfg_wr, .i_cfg_addr, .i_cfg_be,
   .i_cfg_wdata, .o_cfg_rdata, .o_cfg_ack, .i_unsupported_request_flag, .i_end_to_end_crc_flag,
   .i_malformed_packet_flag, .i_receiver_overflow_flag, .i_unexpected_completion_flag, .i_completer_abort_flag,
   .i_completion_timeout_flag, .i_flow_control_protocol_flag, .i_poisoned_packet_flag, .i_surprise_down_flag,
   .i_link_protocol_flag, .i_severity, .o_report_fatal, .o_report_nonfatal, .o_log_valid, .o_log_errors, .o_mask);

// File: aeu_err_src.sv
// Error detection side: drives event pulses and severity into the block
`timescale 1ns/1ps

module aeu_err_src (
   output logic [10:0] o_flags,
   output logic [31:0] o_severity
);
   initial begin
      o_flags = 11'h000;
      o_severity = 32'h0;
   end

   // One call per cycle, just after the clock edge
   task drive(input logic [10:0] f, input logic [31:0] s);
      o_flags = f;
      o_severity = s;
   endtask
endmodule // aeu_err_src

// File: aeu_uncorr_regs_tb.sv
// Self-checking bench for the uncorrectable error registers
`timescale 1ns/1ps

module aeu_uncorr_regs_tb;
   logic        i_clock = 1'b0, i_nrst = 1'b0, i_cfg_rd = 1'b0, i_cfg_wr = 1'b0;
   logic [11:0] i_cfg_addr = 12'h000;
   logic [3:0]  i_cfg_be = 4'h0;
   logic [31:0] i_cfg_wdata = 32'h0, st = 32'h0, mk = 32'h0, r;
   logic [31:0] o_cfg_rdata, o_log_errors, o_mask, i_severity;
   logic [10:0] fl;
   logic        o_cfg_ack, o_report_fatal, o_report_nonfatal, o_log_valid;
   logic [63:0] q_rd[$], ex;
   logic [33:0] q_log[$], el;
   int          mismatches = 0, n_tests = 0, seed = 32'he00c;

   aeu_err_src src (.o_flags(fl), .o_severity(i_severity));

   aeu_uncorr_regs DUT (.i_clock, .i_nrst, .i_cfg_rd, .i_cfg_wr, .i_cfg_addr, .i_cfg_be, .i_cfg_wdata, .o_cfg_rdata,
      .o_cfg_ack, .i_unsupported_request_flag(fl[10]), .i_end_to_end_crc_flag(fl[9]), .i_malformed_packet_flag(fl[8]),
      .i_receiver_overflow_flag(fl[7]), .i_unexpected_completion_flag(fl[6]), .i_completer_abort_flag(fl[5]),
      .i_completion_timeout_flag(fl[4]), .i_flow_control_protocol_flag(fl[3]), .i_poisoned_packet_flag(fl[2]),
      .i_surprise_down_flag(fl[1]), .i_link_protocol_flag(fl[0]), .i_severity, .o_report_fatal, .o_report_nonfatal,
      .o_log_valid, .o_log_errors, .o_mask);

   initial forever #4 i_clock = ~i_clock;

   task summarize;
      if (q_rd.size() != 0 || q_log.size() != 0) mismatches++;
      $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   task cmp_rd(input logic [31:0] got, input logic [63:0] e);
      n_tests++;
      if ((got & e[63:32]) !== (e[31:0] & e[63:32])) begin
         mismatches++;
         $display("CHECK FAILED %0t read %h expected %h", $time, got, e[31:0]);
      end
   endtask

   task cmp_log(input logic [33:0] got, input logic [33:0] e);
      n_tests++;
      if (got !== e) begin
         mismatches++;
         $display("CHECK FAILED %0t report %h expected %h", $time, got, e);
      end
   endtask

   // One cycle of stimulus; the reference model is updated at the same edge
   task automatic cyc(input logic rd, wr, input logic [11:0] a, input logic [3:0] b, input logic [31:0] d,
                      input logic [10:0] f, input logic [31:0] s);
      logic [31:0] e, u, bm;
      e = {11'h000, f[10:2], 6'h00, f[1:0], 4'h0};
      bm = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
      i_cfg_rd = rd;
      i_cfg_wr = wr;
      i_cfg_addr = a;
      i_cfg_be = b;
      i_cfg_wdata = d;
      src.drive(f, s);
      if (rd || wr) q_rd.push_back({rd ? 32'hffff_fffe : 32'h0, a[11:2] == 10'h040 ? 32'h0001_0000 :
         a[11:2] == 10'h041 ? st : a[11:2] == 10'h042 ? mk : 32'h0});
      u = e & ~mk;
      if (u != 32'h0) q_log.push_back({|(u & s), |(u & ~s), u});
      if (wr && a[11:2] == 10'h041) st = st & ~(d & bm);
      if (wr && a[11:2] == 10'h042) mk = (mk & ~bm) | (d & bm & aeu_pkg::AEU_IMPL_MASK);
      st = st | e;
      @(posedge i_clock);
      #1;
   endtask

   always @(negedge i_clock) begin
      if (i_nrst && o_cfg_ack === 1'b1) begin
         ex = q_rd.size() != 0 ? q_rd.pop_front() : {32'hffff_ffff, 32'hx};
         cmp_rd(o_cfg_rdata, ex);
      end
      if (i_nrst && (o_log_valid !== 1'b0 || o_report_fatal !== 1'b0 || o_report_nonfatal !== 1'b0)) begin
         el = q_log.size() != 0 ? q_log.pop_front() : 34'hx;
         cmp_log({o_report_fatal, o_report_nonfatal, o_log_errors}, el);
      end
   end

   initial begin
      #(8 * 3000);
      mismatches++;
      summarize();
   end

   initial begin
      repeat (6) @(posedge i_clock);
      #1;
      i_nrst = 1'b1;
      @(posedge i_clock);
      #1;
      for (int i = 0; i < 6; i++) cyc(1, 0, 12'h100 + 12'(i * 2), 0, 0, 0, 0);
      cyc(0, 1, 12'h100, 4'hf, 32'hffff_ffff, 0, 0);
      cyc(1, 0, 12'h102, 0, 0, 0, 0);
      for (int i = 0; i < 11; i++) begin
         cyc(0, 0, 0, 0, 0, 11'h001 << i, {32{i[0]}});
         cyc(1, 0, 12'h104, 0, 0, 0, 0);
      end
      cyc(0, 1, 12'h104, 4'hf, 32'h0, 0, 0);
      cyc(0, 1, 12'h104, 4'h4, 32'hffff_ffff, 0, 0);
      cyc(1, 0, 12'h104, 0, 0, 0, 0);
      cyc(0, 1, 12'h108, 4'hf, 32'hffff_ffff, 0, 0);
      cyc(1, 0, 12'h108, 0, 0, 11'h7ff, 32'hffff_ffff);
      cyc(0, 1, 12'h104, 4'hf, 32'hffff_ffff, 11'h001, 0);
      cyc(1, 0, 12'h104, 0, 0, 11'h7ff, 0);
      cyc(0, 1, 12'h108, 4'hf, 32'h0, 0, 0);
      cyc(0, 0, 0, 0, 0, 11'h7ff, 32'h0005_a010);
      repeat (400) begin
         r = $random(seed);
         cyc(r[0] & ~r[1], r[1], {8'h10, r[3:2], 2'h0}, r[7:4], $random(seed), r[18:8] & r[29:19], $random(seed));
      end
      repeat (3) cyc(0, 0, 0, 0, 0, 0, 0);
      summarize();
   end
endmodule // aeu_uncorr_regs_tb
